// >>> common/cmp_ctrl_pkg.sv
// Shared constants and bus carriers for the comparator control register bank.
package cmp_ctrl_pkg;

  localparam int          DATA_W         = 32;
  localparam int          ADDR_W         = 32;

  localparam logic [ADDR_W-1:0] OFS_CONTROL    = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 32'h0000_0004;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 32'h0000_0008;

  localparam int          BIT_ON         = 7;
  localparam int          BIT_RESULT     = 6;
  localparam int          BIT_RISE       = 5;
  localparam int          BIT_FALL       = 4;
  localparam int          POS_HI         = 3;
  localparam int          POS_LO         = 2;
  localparam int          NEG_HI         = 1;
  localparam int          NEG_LO         = 0;

  localparam int          IRQ_RISE       = 0;
  localparam int          IRQ_FALL       = 1;

  localparam logic        RST_ON         = 1'b0;
  localparam logic        RST_FLAG       = 1'b0;
  localparam logic [1:0]  RST_HYST       = 2'h0;
  localparam logic [1:0]  RST_IRQ        = 2'h0;
  localparam logic        RST_LEVEL      = 1'b0;

  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } axil_req_t;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic       on;
    logic [1:0] pos_hyst;
    logic [1:0] neg_hyst;
  } cmp_cfg_t;

endpackage : cmp_ctrl_pkg

// >>> src/cmp_edge_sync.sv
// Two-stage synchronizer and edge detector for the comparator output.
`timescale 1ns/1ps
module cmp_edge_sync
(
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_async,
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);
  import cmp_ctrl_pkg::*;

  logic stage1;
  logic stage2;
  logic prev;
  logic next_stage1;
  logic next_stage2;
  logic next_prev;

  always_comb
  begin
    next_stage1 = i_async;
    next_stage2 = stage1;
    next_prev   = stage2;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      stage1 <= RST_LEVEL;
      stage2 <= RST_LEVEL;
      prev   <= RST_LEVEL;
    end
    else
    begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
      prev   <= next_prev;
    end
  end

  // Edges are taken between the second stage and its delayed copy only.
  assign o_level = stage2;
  assign o_rise  = stage2 & ~prev;
  assign o_fall  = ~stage2 & prev;

  AST_EDGE_ONCE: assert property (@(posedge i_clk) disable iff (i_srst)
    o_rise |=> !o_rise)
    else $error("Rising edge pulse lasted more than one cycle.");

  AST_FALL_ONCE: assert property (@(posedge i_clk) disable iff (i_srst)
    o_fall |=> !o_fall)
    else $error("Falling edge pulse lasted more than one cycle.");

endmodule : cmp_edge_sync

// >>> src/cmp_ctrl_regs.sv
// Comparator control and status register bank with an AXI4-Lite slave.
`timescale 1ns/1ps
// Operation
// - Control bit 7 turns the comparator on when one, off when zero.
// - Read-only bit 6 shows the synchronized comparator result.
// - Bit 5 is set by hardware on each rising output edge and stays set until a control write with bit 5 zero.
// - Bit 4 is set by hardware on each falling output edge and stays set until a control write with bit 4 zero.
// - Bits 3:2 select positive hysteresis and drive the analog comparator.
// - Bits 1:0 select negative hysteresis and drive the analog comparator.
module cmp_ctrl_regs
(
  input  wire logic                    i_clk,
  input  wire logic                    i_srst,
  input  wire logic                    i_cmp_raw,
  input  wire cmp_ctrl_pkg::axil_req_t i_axi,
  output cmp_ctrl_pkg::axil_rsp_t      o_axi,
  output cmp_ctrl_pkg::cmp_cfg_t       o_cfg,
  output logic                         o_irq
);
  import cmp_ctrl_pkg::*;

  logic              level;
  logic              rise_evt;
  logic              fall_evt;

  cmp_cfg_t          cfg;
  logic              rise_flag;
  logic              fall_flag;
  logic [1:0]        irq_stat;
  logic [1:0]        irq_mask;
  cmp_cfg_t          next_cfg;
  logic              next_rise_flag;
  logic              next_fall_flag;
  logic [1:0]        next_irq_stat;
  logic [1:0]        next_irq_mask;

  logic              aw_got;
  logic [ADDR_W-1:0] aw_addr;
  logic              w_got;
  logic [DATA_W-1:0] w_data;
  logic              w_lane0;
  logic              bvalid;
  logic [1:0]        bresp;
  logic              rvalid;
  logic [DATA_W-1:0] rdata;
  logic [1:0]        rresp;
  logic              next_aw_got;
  logic [ADDR_W-1:0] next_aw_addr;
  logic              next_w_got;
  logic [DATA_W-1:0] next_w_data;
  logic              next_w_lane0;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_rvalid;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0]        next_rresp;

  logic              do_write;
  logic              wr_ctl;
  logic              wr_stat;
  logic              wr_mask;
  logic              ar_take;
  logic [7:0]        ctl_word;
  logic [DATA_W-1:0] rd_word;
  logic              rd_hit;

  cmp_edge_sync u_sync
  (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_async (i_cmp_raw),
    .o_level (level),
    .o_rise  (rise_evt),
    .o_fall  (fall_evt)
  );

  // Write decode happens once both address and data are held.
  assign do_write = aw_got & w_got & ~bvalid;
  assign wr_ctl   = do_write & w_lane0 & (aw_addr == OFS_CONTROL);
  assign wr_stat  = do_write & w_lane0 & (aw_addr == OFS_IRQ_STATUS);
  assign wr_mask  = do_write & w_lane0 & (aw_addr == OFS_IRQ_MASK);
  assign ar_take  = i_axi.arvalid & ~rvalid;

  always_comb
  begin
    ctl_word             = 8'h00;
    ctl_word[BIT_ON]     = cfg.on;
    ctl_word[BIT_RESULT] = level;
    ctl_word[BIT_RISE]   = rise_flag;
    ctl_word[BIT_FALL]   = fall_flag;
    ctl_word[POS_HI:POS_LO] = cfg.pos_hyst;
    ctl_word[NEG_HI:NEG_LO] = cfg.neg_hyst;
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (i_axi.araddr)
      OFS_CONTROL:    rd_word[7:0] = ctl_word;
      OFS_IRQ_STATUS: rd_word[1:0] = irq_stat;
      OFS_IRQ_MASK:   rd_word[1:0] = irq_mask;
      default:        rd_hit = 1'b0;
    endcase
  end

  always_comb
  begin
    next_cfg = cfg;
    next_irq_mask = irq_mask;
    if (wr_ctl)
    begin
      next_cfg.on       = w_data[BIT_ON];
      next_cfg.pos_hyst = w_data[POS_HI:POS_LO];
      next_cfg.neg_hyst = w_data[NEG_HI:NEG_LO];
    end
    if (wr_mask)
    begin
      next_irq_mask = w_data[1:0];
    end
    // A new edge wins over a clear issued in the same cycle.
    next_rise_flag = rise_evt | (rise_flag & ~(wr_ctl & ~w_data[BIT_RISE]));
    next_fall_flag = fall_evt | (fall_flag & ~(wr_ctl & ~w_data[BIT_FALL]));
    next_irq_stat  = irq_stat & ~(wr_stat ? w_data[1:0] : 2'h0);
    next_irq_stat[IRQ_RISE] = next_irq_stat[IRQ_RISE] | rise_evt;
    next_irq_stat[IRQ_FALL] = next_irq_stat[IRQ_FALL] | fall_evt;
  end

  always_comb
  begin
    next_aw_got  = aw_got;
    next_aw_addr = aw_addr;
    next_w_got   = w_got;
    next_w_data  = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (i_axi.awvalid && !aw_got)
    begin
      next_aw_got  = 1'b1;
      next_aw_addr = i_axi.awaddr;
    end
    if (i_axi.wvalid && !w_got)
    begin
      next_w_got   = 1'b1;
      next_w_data  = i_axi.wdata;
      next_w_lane0 = i_axi.wstrb[0];
    end
    if (do_write)
    begin
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = (wr_ctl || wr_stat || wr_mask || !w_lane0) &&
                    (aw_addr == OFS_CONTROL || aw_addr == OFS_IRQ_STATUS ||
                     aw_addr == OFS_IRQ_MASK) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid && i_axi.bready)
    begin
      next_bvalid = 1'b0;
    end
    if (ar_take)
    begin
      next_rvalid = 1'b1;
      next_rdata  = rd_word;
      next_rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid && i_axi.rready)
    begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      cfg       <= '{on: RST_ON, pos_hyst: RST_HYST, neg_hyst: RST_HYST};
      rise_flag <= RST_FLAG;
      fall_flag <= RST_FLAG;
      irq_stat  <= RST_IRQ;
      irq_mask  <= RST_IRQ;
      aw_got    <= 1'b0;
      aw_addr   <= 32'h0000_0000;
      w_got     <= 1'b0;
      w_data    <= 32'h0000_0000;
      w_lane0   <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      rvalid    <= 1'b0;
      rdata     <= 32'h0000_0000;
      rresp     <= RESP_OKAY;
    end
    else
    begin
      cfg       <= next_cfg;
      rise_flag <= next_rise_flag;
      fall_flag <= next_fall_flag;
      irq_stat  <= next_irq_stat;
      irq_mask  <= next_irq_mask;
      aw_got    <= next_aw_got;
      aw_addr   <= next_aw_addr;
      w_got     <= next_w_got;
      w_data    <= next_w_data;
      w_lane0   <= next_w_lane0;
      bvalid    <= next_bvalid;
      bresp     <= next_bresp;
      rvalid    <= next_rvalid;
      rdata     <= next_rdata;
      rresp     <= next_rresp;
    end
  end

  assign o_axi.awready = ~aw_got;
  assign o_axi.wready  = ~w_got;
  assign o_axi.bvalid  = bvalid;
  assign o_axi.bresp   = bresp;
  assign o_axi.arready = ~rvalid;
  assign o_axi.rvalid  = rvalid;
  assign o_axi.rdata   = rdata;
  assign o_axi.rresp   = rresp;
  assign o_cfg         = cfg;
  assign o_irq         = |(irq_stat & irq_mask);

  AST_ON_FOLLOWS_WRITE: assert property (@(posedge i_clk) disable iff (i_srst)
    wr_ctl |=> o_cfg.on == $past(w_data[BIT_ON]))
    else $error("Enable output does not follow the written bit.");

  AST_RESULT_READ: assert property (@(posedge i_clk) disable iff (i_srst)
    (ar_take && i_axi.araddr == OFS_CONTROL) |=> o_axi.rdata[BIT_RESULT] == $past(level))
    else $error("Read result bit differs from the synchronized output.");

  AST_RISE_SETS: assert property (@(posedge i_clk) disable iff (i_srst)
    rise_evt |=> rise_flag)
    else $error("Rising edge did not set the rising flag.");

  AST_RISE_HOLDS: assert property (@(posedge i_clk) disable iff (i_srst)
    (rise_flag && !(wr_ctl && !w_data[BIT_RISE])) |=> rise_flag)
    else $error("Rising flag cleared without a software write of zero.");

  AST_FALL_SETS: assert property (@(posedge i_clk) disable iff (i_srst)
    fall_evt |=> fall_flag)
    else $error("Falling edge did not set the falling flag.");

  AST_FALL_HOLDS: assert property (@(posedge i_clk) disable iff (i_srst)
    (fall_flag && !(wr_ctl && !w_data[BIT_FALL])) |=> fall_flag)
    else $error("Falling flag cleared without a software write of zero.");

  AST_POS_HYST: assert property (@(posedge i_clk) disable iff (i_srst)
    wr_ctl |=> o_cfg.pos_hyst == $past(w_data[POS_HI:POS_LO]))
    else $error("Positive hysteresis output does not follow the write.");

  AST_NEG_HYST: assert property (@(posedge i_clk) disable iff (i_srst)
    $changed(o_cfg.neg_hyst) |-> $past(wr_ctl))
    else $error("Negative hysteresis changed without a control write.");

  AST_FLAG_AFTER_SYNC: assert property (@(posedge i_clk) disable iff (i_srst)
    $rose(rise_flag) |-> $past(rise_evt))
    else $error("Rising flag set without a synchronized edge.");

endmodule : cmp_ctrl_regs

// >>> bench/cmp_ctrl_regs_bench.sv
// Self-checking testbench for the comparator control register bank.
`timescale 1ns/1ps
module cmp_ctrl_regs_bench;
  import cmp_ctrl_pkg::*;
  logic        clk;
  logic        srst;
  logic        cmp_raw;
  axil_req_t   req;
  axil_rsp_t   rsp;
  cmp_cfg_t    cfg;
  logic        irq;
  int          error_cnt;
  int          n_tests;
  logic [1:0]  resp;
  logic [1:0]  k;

  cmp_ctrl_regs dut
  (
    .i_clk     (clk),
    .i_srst    (srst),
    .i_cmp_raw (cmp_raw),
    .i_axi     (req),
    .o_axi     (rsp),
    .o_cfg     (cfg),
    .o_irq     (irq)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Offers address and data together, holds each until taken, waits for the response.
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    logic aw_hs;
    logic w_hs;
    logic b_hs;
    int   n;
    n = 0;
    b_hs = 1'b0;
    r = 2'h3;
    req.awaddr  <= a;
    req.awvalid <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= s;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    while (!b_hs && n < 50)
    begin
      @(negedge clk);
      aw_hs = req.awvalid & rsp.awready;
      w_hs  = req.wvalid & rsp.wready;
      b_hs  = rsp.bvalid;
      r     = rsp.bresp;
      @(posedge clk);
      if (aw_hs)
        req.awvalid <= 1'b0;
      if (w_hs)
        req.wvalid <= 1'b0;
      n++;
    end
    req.bready <= 1'b0;
    @(posedge clk);
    if (!b_hs)
      error_cnt++;
  endtask : axi_write

  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs;
    logic r_hs;
    int   n;
    n = 0;
    r_hs = 1'b0;
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    while (!r_hs && n < 50)
    begin
      @(negedge clk);
      ar_hs = req.arvalid & rsp.arready;
      r_hs  = rsp.rvalid;
      d     = rsp.rdata;
      r     = rsp.rresp;
      @(posedge clk);
      if (ar_hs)
        req.arvalid <= 1'b0;
      n++;
    end
    req.rready <= 1'b0;
    @(posedge clk);
    if (!r_hs)
      error_cnt++;
  endtask : axi_read

  task automatic wr_chk(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    axi_write(a, d, 4'hF, resp);
    check("bresp", {30'h0, resp}, {30'h0, er});
  endtask : wr_chk

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    axi_read(a, d, resp);
    check("rdata", d, exp);
    check("rresp", {30'h0, resp}, {30'h0, er});
  endtask : rd_chk

  // Samples the configuration and interrupt outputs between clock edges.
  task automatic out_chk(input logic [4:0] ecfg, input logic eirq);
    @(negedge clk);
    check("cfg", {27'h0, cfg}, {27'h0, ecfg});
    check("irq", {31'h0, irq}, {31'h0, eirq});
    @(posedge clk);
  endtask : out_chk

  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end

  initial
  begin
    srst = 1'b1;
    cmp_raw = 1'b0;
    req = '0;
    error_cnt = 0;
    n_tests = 0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    out_chk(5'h00, 1'b0);
    rd_chk(OFS_CONTROL, 32'h0000_0000, RESP_OKAY);
    rd_chk(OFS_IRQ_STATUS, 32'h0000_0000, RESP_OKAY);
    rd_chk(OFS_IRQ_MASK, 32'h0000_0000, RESP_OKAY);
    for (int i = 0; i < 4; i++)
    begin
      k = 2'(i);
      wr_chk(OFS_CONTROL, {24'h000000, k[0], 3'h0, k, ~k}, RESP_OKAY);
      out_chk({k[0], k, ~k}, 1'b0);
      rd_chk(OFS_CONTROL, {24'h000000, k[0], 3'h0, k, ~k}, RESP_OKAY);
    end
    axi_write(OFS_CONTROL, 32'h0000_0073, 4'hE, resp);
    check("bresp", {30'h0, resp}, {30'h0, RESP_OKAY});
    rd_chk(OFS_CONTROL, 32'h0000_008C, RESP_OKAY);
    cmp_raw <= 1'b1;
    repeat (6) @(posedge clk);
    rd_chk(OFS_CONTROL, 32'h0000_00EC, RESP_OKAY);
    rd_chk(OFS_IRQ_STATUS, 32'h0000_0001, RESP_OKAY);
    out_chk(5'h1C, 1'b0);
    wr_chk(OFS_IRQ_MASK, 32'h0000_0003, RESP_OKAY);
    out_chk(5'h1C, 1'b1);
    cmp_raw <= 1'b0;
    repeat (6) @(posedge clk);
    rd_chk(OFS_CONTROL, 32'h0000_00BC, RESP_OKAY);
    rd_chk(OFS_CONTROL, 32'h0000_00BC, RESP_OKAY);
    wr_chk(OFS_CONTROL, 32'h0000_009C, RESP_OKAY);
    rd_chk(OFS_CONTROL, 32'h0000_009C, RESP_OKAY);
    wr_chk(OFS_CONTROL, 32'h0000_008C, RESP_OKAY);
    rd_chk(OFS_CONTROL, 32'h0000_008C, RESP_OKAY);
    wr_chk(OFS_IRQ_STATUS, 32'h0000_0001, RESP_OKAY);
    rd_chk(OFS_IRQ_STATUS, 32'h0000_0002, RESP_OKAY);
    out_chk(5'h1C, 1'b1);
    wr_chk(OFS_IRQ_STATUS, 32'h0000_0002, RESP_OKAY);
    out_chk(5'h1C, 1'b0);
    wr_chk(32'h0000_000C, 32'h0000_00FF, RESP_SLVERR);
    rd_chk(32'h0000_000C, 32'h0000_0000, RESP_SLVERR);
    out_chk(5'h1C, 1'b0);
    tally_and_finish();
  end
endmodule : cmp_ctrl_regs_bench
